//--- logic/parser_pkg.sv
// Shared constants and carriers for the message syntax parser
package parser_pkg;
  // Syntax characters
  localparam logic [7:0] CH_NL    = 8'h0a;
  localparam logic [7:0] CH_SP    = 8'h20;
  localparam logic [7:0] CH_COMMA = 8'h2c;
  localparam logic [7:0] CH_SEMI  = 8'h3b;
  localparam logic [7:0] CH_COLON = 8'h3a;
  localparam logic [7:0] CH_STAR  = 8'h2a;
  localparam logic [7:0] CH_QUERY = 8'h3f;
  localparam logic [7:0] CH_0     = 8'h30;
  localparam logic [7:0] CH_9     = 8'h39;
  localparam logic [7:0] CH_LC_A  = 8'h61;
  localparam logic [7:0] CH_LC_Z  = 8'h7a;
  localparam logic [7:0] CASE_BIT = 8'h20;
  localparam logic [7:0] TEN      = 8'h0a;
  // Index assumed when none is given
  localparam logic [7:0] DEFAULT_INDEX = 8'h01;
  // Sizes
  localparam int FIFO_WIDTH = 9;
  localparam int FIFO_DEPTH = 4;
  localparam logic [16:0] TX_FULL = 17'h1_0000;
  localparam logic [2:0] MAX_LEVELS = 3'h4;
  // Received byte with END indication
  typedef struct packed {
    logic [7:0] data;
    logic       eoi;
  } rx_byte_t;
  // Response byte from the executor
  typedef struct packed {
    logic [7:0] data;
    logic       unit_last;
    logic       msg_last;
  } resp_byte_t;
  // Byte sent back to the controller
  typedef struct packed {
    logic [7:0] data;
    logic       eoi;
  } tx_byte_t;
  // One decoded program unit
  typedef struct packed {
    logic [3:0][31:0] path;
    logic [2:0]       depth;
    logic [7:0]       index;
    logic [7:0]       key_len;
    logic             common;
    logic             query;
    logic [7:0]       nparams;
  } unit_t;
  // Protocol error pulses
  typedef struct packed {
    logic interrupted;
    logic no_response;
    logic early_read;
    logic incomplete;
  } err_t;
  // Parser phase
  typedef enum logic [1:0] {PH_START, PH_HDR, PH_DATA, PH_SKIP} phase_t;
endpackage

//--- logic/message_syntax_parser.sv
// Receive FIFO and the program/response message parser
`timescale 1ns/1ps
`default_nettype none

// Small FIFO between the bus and the parser
module byte_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_reset,
  // Fill side
  input  wire logic [WIDTH-1:0] i_in,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  // Drain side
  output logic [WIDTH-1:0]      o_out,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  // Whole FIFO state
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } fifo_t;
  fifo_t s_reg, s_next;
  logic push, pop;
  // Honest flags from the count
  assign o_in_ready  = s_reg.cnt != (AW+1)'(DEPTH);
  assign o_out_valid = s_reg.cnt != '0;
  assign o_out       = s_reg.mem[s_reg.rp];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;
  // Pointer and count update
  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.mem[s_reg.wp] = i_in;
      s_next.wp = AW'(s_reg.wp + 1'b1);
    end
    if (pop) begin
      s_next.rp = AW'(s_reg.rp + 1'b1);
    end
    s_next.cnt = (AW+1)'(s_reg.cnt + push - pop);
  end
  // State register
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule

// How it works
// (R01) Space ends header, commas count parameters
// (R02) Semicolon inserted between response units
// (R03) Response ends with newline carrying END
// (R04) Response header and data passed through
// (R05) Responses buffered in arrival order
// (R06) Controller reads whole response first
// (R07) New message mid-read: error, discard
// (R08) Read with nothing pending or early: error
// (R09) Incomplete unit skips rest of message
// (R10) 64 KB response buffer, deadlock flagged
// (R11) Controller keeps messages under 64 KB
// (R12) Leading asterisk marks common command
// (R13) Colon descends one hierarchy level
// (R14) Unprefixed unit resumes remembered level
// (R15) Leading colon restarts from root
// (R16) Common command ignores current level
// (R17) Terminator clears remembered level
// (R18) Mnemonics folded to upper case
// (R19) First four letters kept for matching
// (R20) Trailing question mark marks query
// (R21) Missing numeric index becomes one
// (R22) Optional parts left to unit matching
// (R23) Newline, END or both end message
// (R24) Semicolon separates units, kept in order
module message_syntax_parser (
  // Clock and reset
  input  wire logic                   i_clock,
  input  wire logic                   i_reset,
  // Program bytes from the bus listener
  input  wire parser_pkg::rx_byte_t   i_rx,
  input  wire logic                   i_rx_valid,
  output logic                        o_rx_ready,
  // Decoded units to the executor
  output parser_pkg::unit_t           o_unit,
  output logic                        o_unit_valid,
  input  wire logic                   i_unit_ready,
  // Response bytes from the executor
  input  wire parser_pkg::resp_byte_t i_resp,
  input  wire logic                   i_resp_valid,
  output logic                        o_resp_ready,
  // Response bytes to the bus talker
  output parser_pkg::tx_byte_t        o_tx,
  output logic                        o_tx_valid,
  input  wire logic                   i_tx_ready,
  // Status
  input  wire logic                   i_discard,
  output parser_pkg::err_t            o_err,
  output logic                        o_deadlock
);
  import parser_pkg::*;

  // Whole parser state
  typedef struct packed {
    phase_t           phase;
    logic [3:0][31:0] path;
    logic [2:0]       depth;
    logic [2:0]       base;
    logic [31:0]      key;
    logic [7:0]       klen;
    logic [7:0]       index;
    logic             has_index;
    logic             common;
    logic             query;
    logic [7:0]       commas;
    logic             data_seen;
    logic             need_item;
    logic             bad;
    logic             msg_open;
    unit_t            unit;
    logic             unit_valid;
    err_t             err;
    logic [15:0]      wr;
    logic [15:0]      rd;
    logic [16:0]      count;
    logic [16:0]      msgs;
    logic             reading;
    logic             sep_needed;
    logic             nl_pending;
    logic             tx_ready_prev;
  } state_t;

  state_t s_reg, s_next;
  rx_byte_t fifo_out;       // Byte at FIFO head
  logic fifo_valid;         // FIFO holds a byte
  logic pop;                // Parser takes the byte
  logic wr_en;              // Buffer write strobe
  tx_byte_t wr_data;        // Byte being buffered
  logic rx_busy;            // Program message still arriving
  tx_byte_t tx_mem [0:65535]; // Response buffer, 64 KB

  // Four-word FIFO absorbs bursts; parser stall fills it
  byte_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) rx_fifo (
    .i_clock     (i_clock),
    .i_reset     (i_reset),
    .i_in        (i_rx),
    .i_in_valid  (i_rx_valid),
    .o_in_ready  (o_rx_ready),
    .o_out       (fifo_out),
    .o_out_valid (fifo_valid),
    .i_out_ready (pop)
  );

  // Parser stalls while a unit waits for the executor
  assign pop     = fifo_valid && !(s_reg.unit_valid && !i_unit_ready);
  assign rx_busy = fifo_valid || s_reg.msg_open;

  // Close the mnemonic being collected
  function automatic state_t close_mn(state_t s);
    if (s.klen == '0 || s.depth >= MAX_LEVELS) begin
      s.bad = 1'b1;
    end else if (!s.common) begin
      // (R13) descend one level
      s.path[s.depth[1:0]] = s.key;
      s.depth = 3'(s.depth + 1'b1);
    end
    // (R21) default index
    s.index = s.has_index ? s.index : DEFAULT_INDEX;
    s.unit.key_len = s.klen;
    s.key = '0;
    s.klen = '0;
    s.has_index = 1'b0;
    return s;
  endfunction

  // One header character
  function automatic state_t hdr_char(state_t s, logic [7:0] c);
    logic [7:0] uc;
    uc = c;
    // (R18) fold case
    if (c >= CH_LC_A && c <= CH_LC_Z) begin
      uc = c - CASE_BIT;
    end
    if (c == CH_COLON) begin
      s = close_mn(s);
    end else if (c == CH_QUERY) begin
      // (R20) query marker
      s.query = 1'b1;
    end else if (c == CH_SP) begin
      // (R01) header to data
      s = close_mn(s);
      s.phase = PH_DATA;
    end else if (s.query) begin
      // No letter or digit may follow the marker
      s.bad = 1'b1;
    end else if (c >= CH_0 && c <= CH_9) begin
      // First digit restarts, so an earlier level's index never leaks in
      s.index = s.has_index ? 8'(s.index * TEN + (c - CH_0)) : 8'(c - CH_0);
      s.has_index = 1'b1;
    end else begin
      // (R19) keep short form letters
      if (s.klen < 8'h04) begin
        s.key[int'(2'd3 - s.klen[1:0]) * 8 +: 8] = uc;
      end
      if (s.klen != 8'hff) begin
        s.klen = 8'(s.klen + 1'b1);
      end
    end
    return s;
  endfunction

  // Next-state logic for parser and response buffer
  always_comb begin
    logic [7:0] c;
    logic term;
    logic rd_fire;
    logic discard;
    c = fifo_out.data;
    term = 1'b0;
    rd_fire = 1'b0;
    discard = 1'b0;
    s_next = s_reg;
    s_next.err = '0;
    wr_en = 1'b0;
    wr_data = '0;
    if (i_unit_ready) begin
      s_next.unit_valid = 1'b0;
    end
    // Program side, one byte per cycle
    if (pop) begin
      // (R23) three terminator forms
      term = (c == CH_NL) || fifo_out.eoi;
      s_next.msg_open = 1'b1;
      if (c != CH_NL && s_next.phase != PH_SKIP) begin
        if (c == CH_SEMI) begin
          // (R24) unit boundary
          term = term;
        end else if (s_next.phase == PH_START) begin
          if (c != CH_SP) begin
            s_next.key = '0;
            s_next.klen = '0;
            s_next.has_index = 1'b0;
            s_next.index = '0;
            s_next.query = 1'b0;
            s_next.common = 1'b0;
            s_next.commas = '0;
            s_next.data_seen = 1'b0;
            s_next.need_item = 1'b0;
            s_next.bad = 1'b0;
            s_next.phase = PH_HDR;
            if (c == CH_COLON) begin
              // (R15) from the root
              s_next.depth = '0;
              s_next.path = '0;
            end else if (c == CH_STAR) begin
              // (R12) (R16) common, level free
              s_next.common = 1'b1;
              s_next.depth = '0;
            end else begin
              // (R14) resume remembered level
              s_next.depth = s_next.base;
              s_next = hdr_char(s_next, c);
            end
          end
        end else if (s_next.phase == PH_HDR) begin
          s_next = hdr_char(s_next, c);
        end else if (c == CH_COMMA) begin
          // (R01) another parameter follows
          s_next.commas = 8'(s_next.commas + 1'b1);
          s_next.need_item = 1'b1;
        end else if (c != CH_SP) begin
          s_next.data_seen = 1'b1;
          s_next.need_item = 1'b0;
        end
      end
      // Unit end on semicolon or terminator
      if ((c == CH_SEMI || term) && (s_next.phase == PH_HDR || s_next.phase == PH_DATA)) begin
        if (s_next.phase == PH_HDR) begin
          s_next = close_mn(s_next);
        end
        if (s_next.need_item) begin
          s_next.bad = 1'b1;
        end
        if (s_next.bad) begin
          // (R09) skip remaining units
          s_next.err.incomplete = 1'b1;
          s_next.phase = PH_SKIP;
        end else begin
          // (R22) depth and key length let optional parts match
          s_next.unit.path = s_next.path;
          s_next.unit.depth = s_next.depth;
          s_next.unit.index = s_next.index;
          s_next.unit.common = s_next.common;
          s_next.unit.query = s_next.query;
          s_next.unit.nparams = s_next.data_seen ? 8'(s_next.commas + 1'b1) : '0;
          s_next.unit_valid = 1'b1;
          if (!s_next.common && s_next.depth != '0) begin
            s_next.base = 3'(s_next.depth - 1'b1);
          end
          s_next.phase = PH_START;
        end
      end
      if (term) begin
        // (R17) forget the level
        s_next.base = '0;
        s_next.path = '0;
        s_next.phase = PH_START;
        s_next.msg_open = 1'b0;
      end
    end
    // Response writer, separators and terminator
    if (s_reg.count != TX_FULL) begin
      if (s_reg.nl_pending) begin
        // (R03) newline with END
        wr_en = 1'b1;
        wr_data = '{data: CH_NL, eoi: 1'b1};
        s_next.nl_pending = 1'b0;
        s_next.msgs = 17'(s_reg.msgs + 1'b1);
      end else if (i_resp_valid && s_reg.sep_needed) begin
        // (R02) unit separator
        wr_en = 1'b1;
        wr_data = '{data: CH_SEMI, eoi: 1'b0};
        s_next.sep_needed = 1'b0;
      end else if (i_resp_valid) begin
        // (R04) (R05) bytes kept in order
        wr_en = 1'b1;
        wr_data = '{data: i_resp.data, eoi: 1'b0};
        s_next.nl_pending = i_resp.msg_last;
        s_next.sep_needed = i_resp.unit_last && !i_resp.msg_last;
      end
    end
    if (wr_en) begin
      s_next.wr = 16'(s_reg.wr + 1'b1);
    end
    // Reader side
    rd_fire = o_tx_valid && i_tx_ready;
    if (rd_fire) begin
      s_next.rd = 16'(s_reg.rd + 1'b1);
      s_next.reading = !o_tx.eoi;
      if (o_tx.eoi) begin
        s_next.msgs = 17'(s_next.msgs - 1'b1);
      end
    end
    s_next.count = 17'(s_reg.count + wr_en - rd_fire);
    // (R08) read with nothing to give
    s_next.tx_ready_prev = i_tx_ready;
    if (i_tx_ready && !s_reg.tx_ready_prev && !o_tx_valid) begin
      if (rx_busy) begin
        s_next.err.early_read = 1'b1;
      end else if (s_reg.msgs == '0) begin
        s_next.err.no_response = 1'b1;
      end
    end
    // (R07) new message cuts a partial read
    if (i_rx_valid && o_rx_ready && s_reg.reading) begin
      s_next.err.interrupted = 1'b1;
      discard = 1'b1;
    end
    // (R10) software discard clears deadlock
    if (discard || i_discard) begin
      s_next.rd = s_reg.wr;
      s_next.count = {16'h0000, wr_en};
      s_next.msgs = {16'h0000, s_reg.nl_pending && wr_en};
      s_next.reading = 1'b0;
    end
  end

  // State register
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Buffer storage, no reset needed for data
  always_ff @(posedge i_clock) begin
    if (wr_en) begin
      tx_mem[s_reg.wr] <= wr_data;
    end
  end

  // Outputs; talker waits until the message is complete
  assign o_tx_valid   = s_reg.msgs != '0 && !rx_busy;
  assign o_tx         = o_tx_valid ? tx_mem[s_reg.rd] : '0;
  assign o_resp_ready = s_reg.count != TX_FULL && !s_reg.nl_pending && !s_reg.sep_needed;
  assign o_unit       = s_reg.unit;
  assign o_unit_valid = s_reg.unit_valid;
  assign o_err        = s_reg.err;
  // (R10) both buffers full
  assign o_deadlock   = !o_rx_ready && s_reg.count == TX_FULL;

  // Any lower-case letter left in a path
  function automatic logic has_lower(logic [3:0][31:0] p);
    logic r;
    r = 1'b0;
    for (int i = 0; i < 16; i++) begin
      if (p[i/4][(i%4)*8 +: 8] >= CH_LC_A && p[i/4][(i%4)*8 +: 8] <= CH_LC_Z) begin
        r = 1'b1;
      end
    end
    return r;
  endfunction

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  property p_term_clears;
    pop && (fifo_out.data == CH_NL || fifo_out.eoi) |=> s_reg.base == '0 && s_reg.phase == PH_START;
  endproperty
  a_term_clears: assert property (p_term_clears) else $error("level kept after terminator"); // (R17)
  property p_skip;
    s_reg.phase == PH_SKIP |=> !$rose(o_unit_valid);
  endproperty
  a_skip: assert property (p_skip) else $error("unit issued after incomplete one"); // (R09)
  property p_nl_end;
    o_tx_valid && o_tx.eoi |-> o_tx.data == CH_NL;
  endproperty
  a_nl_end: assert property (p_nl_end) else $error("END without newline"); // (R03)
  property p_sep;
    i_resp_valid && s_reg.sep_needed && !s_reg.nl_pending && s_reg.count != TX_FULL
      |-> wr_en && wr_data.data == CH_SEMI ##1 !s_reg.sep_needed;
  endproperty
  a_sep: assert property (p_sep) else $error("separator missing"); // (R02)
  property p_interrupt;
    i_rx_valid && o_rx_ready && s_reg.reading |=> o_err.interrupted && !s_reg.reading && s_reg.count <= 17'h0_0001;
  endproperty
  a_interrupt: assert property (p_interrupt) else $error("partial response kept"); // (R07)
  property p_no_resp;
    o_err.no_response |-> $past(i_tx_ready) && !$past(o_tx_valid) && $past(s_reg.msgs) == '0;
  endproperty
  a_no_resp: assert property (p_no_resp) else $error("spurious no-response error"); // (R08)
  property p_upper;
    $rose(o_unit_valid) |-> !has_lower(o_unit.path);
  endproperty
  a_upper: assert property (p_upper) else $error("lower case in header"); // (R18)
  property p_deadlock;
    o_deadlock |-> s_reg.count == TX_FULL && !o_resp_ready;
  endproperty
  a_deadlock: assert property (p_deadlock) else $error("deadlock without full buffer"); // (R10)
  property p_root;
    pop && s_reg.phase == PH_START && fifo_out.data == CH_COLON && !fifo_out.eoi |=> s_reg.depth == '0;
  endproperty
  a_root: assert property (p_root) else $error("root not restored"); // (R15)

  c_query: cover property ($rose(o_unit_valid) && o_unit.query);
  c_tx_end: cover property (o_tx_valid && i_tx_ready && o_tx.eoi);
  c_incomplete: cover property (o_err.incomplete);
  c_deadlock: cover property (o_deadlock);
endmodule

`default_nettype wire

//--- verif/remote_controller.sv
// Behavioural model of the remote bus controller
`timescale 1ns/1ps
`default_nettype none
module remote_controller (
  // Clock
  input  wire logic                 i_clock,
  // Program bytes toward the device
  output parser_pkg::rx_byte_t      o_rx,
  output logic                      o_rx_valid,
  input  wire logic                 i_rx_ready,
  // Response bytes from the device
  input  wire parser_pkg::tx_byte_t i_tx,
  input  wire logic                 i_tx_valid,
  output logic                      o_tx_ready
);
  import parser_pkg::*;

  // Idle at time zero
  initial begin
    o_rx       = '0;
    o_rx_valid = 1'b0;
    o_tx_ready = 1'b0;
  end

  // text as given, short messages only
  task automatic send(input string s, input bit end_flag);
    int k;
    int w;
    for (k = 0; k < s.len(); k++) begin
      @(negedge i_clock);
      o_rx_valid = 1'b1;
      // END rides on the final byte when asked
      o_rx = '{data: s[k], eoi: end_flag && (k == s.len() - 1)};
      w = 0;
      do begin
        @(posedge i_clock);
        w++;
      end while (i_rx_ready !== 1'b1 && w < 500);
    end
    @(negedge i_clock);
    o_rx_valid = 1'b0;
    // Released bus shows the inverse, not a stale byte
    o_rx = ~o_rx;
  endtask

  // hold ready until n bytes are taken; blind reads probe errors
  task automatic read(input int n, input bit wait_valid);
    int got;
    int w;
    got = 0;
    w = 0;
    @(negedge i_clock);
    while (wait_valid && i_tx_valid !== 1'b1 && w < 200) begin
      @(negedge i_clock);
      w++;
    end
    o_tx_ready = 1'b1;
    while (got < n && w < 400) begin
      @(posedge i_clock);
      w++;
      if (i_tx_valid === 1'b1) got++;
    end
    @(negedge i_clock);
    o_tx_ready = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- verif/tb_message_syntax_parser.sv
// Self-checking bench for the message syntax parser
`timescale 1ns/1ps
`default_nettype none
module tb_message_syntax_parser;
  import parser_pkg::*;
  localparam int LIMIT = 20000;  // Cycle ceiling, far above the run
  logic       i_clock;
  logic       i_reset;
  rx_byte_t   rx;
  logic       rx_valid;
  logic       rx_ready;
  unit_t      unit;
  logic       unit_valid;
  logic       unit_ready;
  resp_byte_t resp;
  logic       resp_valid;
  logic       resp_ready;
  tx_byte_t   tx;
  logic       tx_valid;
  logic       tx_ready;
  logic       discard;
  err_t       err;
  logic       deadlock;
  logic       stall;        // Executor refuses units
  logic [31:0] seed;        // Random source
  int         n_errors;
  int         check_count;
  int         cycles;
  unit_t      eu[$];        // Expected units
  logic [8:0] eb[$];        // Expected response bytes with END
  err_t       ee[$];        // Expected error pulses

  message_syntax_parser message_syntax_parser_inst (
    .i_clock(i_clock), .i_reset(i_reset), .i_rx(rx), .i_rx_valid(rx_valid), .o_rx_ready(rx_ready),
    .o_unit(unit), .o_unit_valid(unit_valid), .i_unit_ready(unit_ready), .i_resp(resp),
    .i_resp_valid(resp_valid), .o_resp_ready(resp_ready), .o_tx(tx), .o_tx_valid(tx_valid),
    .i_tx_ready(tx_ready), .i_discard(discard), .o_err(err), .o_deadlock(deadlock));

  remote_controller remote_controller_inst (
    .i_clock(i_clock), .o_rx(rx), .o_rx_valid(rx_valid), .i_rx_ready(rx_ready),
    .i_tx(tx), .i_tx_valid(tx_valid), .o_tx_ready(tx_ready));

  // Galois-free shift register for stall patterns
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Expected unit from its fields
  function automatic unit_t mk(input logic [31:0] a, input logic [31:0] b, input logic [2:0] d,
                               input logic [7:0] ix, input logic [7:0] kl, input logic c,
                               input logic q, input logic [7:0] np);
    unit_t u;
    u = '0;
    u.path[0] = a;
    u.path[1] = b;
    u.depth = d;
    u.index = ix;
    u.key_len = kl;
    u.common = c;
    u.query = q;
    u.nparams = np;
    return u;
  endfunction

  // Common commands: only common flag, depth and query are compared
  task automatic chk_unit(input unit_t g, input unit_t e);
    logic ok;
    ok = e.common ? ({g.common, g.depth, g.query} === {e.common, e.depth, e.query}) : (g === e);
    check_count++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("[ERR] %0t unit got %h exp %h", $time, g, e);
    end
  endtask

  // Plain value comparison
  task automatic chk_val(input logic [63:0] g, input logic [63:0] e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  // Response text as expected on the bus
  task automatic exp_tx(input string s);
    for (int k = 0; k < s.len(); k++) eb.push_back({s[k], 1'b0});
  endtask

  // Executor hands one response unit over
  task automatic resp_unit(input string s, input bit last);
    for (int k = 0; k < s.len(); k++) begin
      @(negedge i_clock);
      resp = '{data: s[k], unit_last: !last && k == s.len() - 1, msg_last: last && k == s.len() - 1};
      resp_valid = 1'b1;
      do @(posedge i_clock); while (resp_ready !== 1'b1);
    end
    @(negedge i_clock);
    resp_valid = 1'b0;
  endtask

  // Wait, bounded, for every expected unit and error to be met
  task automatic drain();
    for (int w = 0; w < 400 && (eu.size() + ee.size()) != 0; w++) @(negedge i_clock);
    repeat (5) @(negedge i_clock);
    chk_val(eu.size() + ee.size(), 0);
  endtask

  // Verdict and end of run
  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Clock at 20 MHz
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end

  // Random executor stalls on the falling edge
  always @(negedge i_clock) begin
    seed <= lfsr(seed);
    unit_ready <= !stall && seed[0];
  end

  // Result watchers: pop the oldest note per result
  always @(posedge i_clock) begin
    if (i_reset === 1'b0) begin
      if (unit_valid === 1'b1 && unit_ready === 1'b1) chk_unit(unit, eu.size() ? eu.pop_front() : '1);
      if (tx_valid === 1'b1 && tx_ready === 1'b1) chk_val({tx.data, tx.eoi}, eb.size() ? eb.pop_front() : '1);
      if (err !== '0) chk_val(err, ee.size() ? ee.pop_front() : '0);
    end
  end

  // Hang guard
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_errors++;
      conclude();
    end
  end

  // Main sequence
  initial begin
    n_errors = 0;
    check_count = 0;
    cycles = 0;
    seed = 32'h0000_4466;
    stall = 1'b1;
    unit_ready = 1'b0;
    resp = '0;
    resp_valid = 1'b0;
    discard = 1'b0;
    i_reset = 1'b1;
    repeat (20) @(negedge i_clock);
    i_reset = 1'b0;
    // Relative level, case, full and short forms, FIFO refusal
    eu.push_back(mk("SOUR", "FUNC", 3'h2, 8'h01, 8'h08, 1'b0, 1'b0, 8'h01));
    eu.push_back(mk("SOUR", "RANG", 3'h2, 8'h01, 8'h04, 1'b0, 1'b0, 8'h02));
    fork
      remote_controller_inst.send(":SOURce:FUNCtion VOLT;RANG 1,2\n", 1'b0);
    join_none
    repeat (60) @(negedge i_clock);
    chk_val(rx_ready, 1'b0);
    stall = 1'b0;
    drain();
    // Common command keeps the level; END ends the message
    eu.push_back(mk("OUTP", "STAT", 3'h2, 8'h01, 8'h04, 1'b0, 1'b0, 8'h01));
    eu.push_back(mk(0, 0, 3'h0, 8'h01, 8'h00, 1'b1, 1'b0, 8'h00));
    eu.push_back(mk("OUTP", "FILT", 3'h2, 8'h02, 8'h04, 1'b0, 1'b0, 8'h00));
    remote_controller_inst.send(":OUTP:STAT 1;*CLS;FILT2", 1'b1);
    drain();
    // Fresh context, query, default index
    eu.push_back(mk("FILT", 0, 3'h1, 8'h01, 8'h04, 1'b0, 1'b1, 8'h00));
    remote_controller_inst.send("filt?\n", 1'b0);
    drain();
    // Incomplete unit skips the rest
    ee.push_back('{incomplete: 1'b1, default: 1'b0});
    remote_controller_inst.send(":SOUR::FUNC 1;:OUTP 1\n", 1'b0);
    eu.push_back(mk("OUTP", 0, 3'h1, 8'h01, 8'h04, 1'b0, 1'b0, 8'h01));
    remote_controller_inst.send(":OUTP 1\n", 1'b0);
    drain();
    // Read with nothing pending, then read during a message
    ee.push_back('{no_response: 1'b1, default: 1'b0});
    remote_controller_inst.read(0, 1'b0);
    drain();
    ee.push_back('{early_read: 1'b1, default: 1'b0});
    eu.push_back(mk("OUTP", "STAT", 3'h2, 8'h01, 8'h04, 1'b0, 1'b0, 8'h01));
    fork
      remote_controller_inst.send(":OUTP:STAT 0\n", 1'b0);
      begin
        repeat (4) @(negedge i_clock);
        remote_controller_inst.read(0, 1'b0);
      end
    join
    drain();
    // Two units with data list, separator and terminator
    exp_tx("1,5;2");
    eb.push_back({CH_NL, 1'b1});
    resp_unit("1,5", 1'b0);
    resp_unit("2", 1'b1);
    remote_controller_inst.read(6, 1'b1);
    drain();
    chk_val(eb.size(), 0);
    // New message during a partial read
    exp_tx("A");
    resp_unit("AB", 1'b1);
    remote_controller_inst.read(1, 1'b1);
    ee.push_back('{interrupted: 1'b1, default: 1'b0});
    eu.push_back(mk(0, 0, 3'h0, 8'h01, 8'h00, 1'b1, 1'b0, 8'h00));
    remote_controller_inst.send("*RST\n", 1'b0);
    drain();
    chk_val(tx_valid, 1'b0);
    // Discard drops a waiting response
    resp_unit("5", 1'b1);
    repeat (4) @(negedge i_clock);
    chk_val(tx_valid, 1'b1);
    discard = 1'b1;
    @(negedge i_clock);
    discard = 1'b0;
    repeat (2) @(negedge i_clock);
    chk_val(tx_valid, 1'b0);
    chk_val(deadlock, 1'b0);
    conclude();
  end
endmodule
`default_nettype wire
